// File: wdt_cfg.sv
`timescale 1ns/1ps
// What this block does
// [RL1] Bus watchdog period code 0 disables; codes 1..3 pick 1.33, 35.7, 41.7 ms.
// [RL2] Global low-power bit set drives global low-power signal high.
// [RL3] Global low-power output is register bit OR pin-zero alternate input.
// [RL4] Software writes one to reserved bit 4 and ignores its read value.
// [RL5] Sleep auto-clear bit set clears the watchdog counter while asleep.
// [RL6] Watchdog enable bit runs the timer when one, stops it when zero.
// [RL7] Without enable lock, software may set or clear enable at any time.
// [RL8] With enable lock, once set, enable stays on until global shutdown.
// [RL9] With enable lock, power-off request also stops the locked watchdog.
// [RL10] Watchdog period codes select 2, 16, 64 and 128 seconds.
// [RL11] Software should clear the counter before changing an unlocked period.
// [RL12] With period lock, period writes are taken only while enable is zero.
// [RL13] Writing 0b01 to the clear field restarts the watchdog counter.
// [RL14] The clear field returns to 0b00 by itself and reads zero; the code reads back the written code in the one cycle it is held.
// [RL15] Clear codes 0b00, 0b10, 0b11 leave the counter unchanged.
// [RL16] Enabled watchdog counts time and flags timeout if not cleared.
module wdt_cfg #(
   parameter int TICK_CYCLES = wdt_cfg_pkg::TICK_CYCLES,
   parameter int BUS_WD_1_CYCLES = wdt_cfg_pkg::BUS_WD_1_CYCLES,
   parameter int BUS_WD_2_CYCLES = wdt_cfg_pkg::BUS_WD_2_CYCLES,
   parameter int BUS_WD_3_CYCLES = wdt_cfg_pkg::BUS_WD_3_CYCLES,
   parameter int MS_PER_S = wdt_cfg_pkg::MS_PER_S
) (
   input wire logic I_MCLK,
   input wire logic I_RST_B,
   input wire logic i_shutdown,
   input wire logic i_power_off_request,
   input wire logic i_fused_enable_lock,
   input wire logic i_fused_period_lock,
   input wire logic i_sleep,
   input wire logic i_general_pin_zero_lp,
   input wire logic i_bus_activity,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_global_low_power,
   output logic o_sys_watchdog_timeout,
   output logic o_bus_watchdog_timeout,
   output logic [1:0] o_bus_watchdog_period
);
   typedef struct packed {
      logic [1:0] bus_watchdog_period;
      logic global_low_power;
      logic reserved_one;
      logic sleep_auto_clear;
      logic sys_watchdog_enable;
      logic [1:0] sys_watchdog_period;
      logic [1:0] sys_watchdog_clear;
      logic [1:0] pin_sync;
      logic [1:0] sleep_sync;
      logic [1:0] lock_e_sync;
      logic [1:0] lock_p_sync;
      logic [1:0] pwroff_sync;
      logic [31:0] tick_cnt;
      logic [31:0] ms_cnt;
      logic [31:0] bus_cnt;
      logic sys_timeout;
      logic bus_timeout;
      logic [7:0] rdata;
   } state_t;

   // All state lives in one packed struct so reset and shutdown clear it in one place.
   // The counters are wide on purpose: the longest period must fit without a carry,
   // and the prescaler keeps the second counter in milliseconds rather than clocks.
   // A shortened time base in test only changes the parameters, never this struct.
   state_t cur;
   state_t nxt;
   logic [31:0] sys_limit;
   logic [31:0] bus_limit;
   logic lock_e;
   logic lock_p;
   logic wr_cfg;
   logic wr_clr;
   logic sys_run;
   logic sys_restart;

   // Second stage of each synchroniser is the only one read by logic
   assign lock_e = cur.lock_e_sync[1];
   assign lock_p = cur.lock_p_sync[1];
   assign wr_cfg = i_wr && (i_addr == wdt_cfg_pkg::LOWPOWER_CONFIG_ADDR);
   assign wr_clr = i_wr && (i_addr == wdt_cfg_pkg::CLEAR_CONTROL_ADDR);
   assign sys_run = cur.sys_watchdog_enable; // [RL6]
   // Counter restarts on the clear command or asleep with auto-clear
   assign sys_restart = (cur.sys_watchdog_clear == wdt_cfg_pkg::CLEAR_CODE) // [RL13]
      || (cur.sleep_auto_clear && cur.sleep_sync[1]); // [RL5]

   // Period decode, in ms ticks for the system watchdog
   // Bus watchdog limit is in clocks, since its periods are far below one second;
   // a zero limit is the disabled code and stops the bus counter entirely
   always_comb begin
      case (cur.sys_watchdog_period) // [RL10]
         2'h0: sys_limit = 32'(wdt_cfg_pkg::SYS_WD_0_S * MS_PER_S);
         2'h1: sys_limit = 32'(wdt_cfg_pkg::SYS_WD_1_S * MS_PER_S);
         2'h2: sys_limit = 32'(wdt_cfg_pkg::SYS_WD_2_S * MS_PER_S);
         default: sys_limit = 32'(wdt_cfg_pkg::SYS_WD_3_S * MS_PER_S);
      endcase
      case (cur.bus_watchdog_period) // [RL1]
         2'h1: bus_limit = 32'(BUS_WD_1_CYCLES);
         2'h2: bus_limit = 32'(BUS_WD_2_CYCLES);
         2'h3: bus_limit = 32'(BUS_WD_3_CYCLES);
         default: bus_limit = 32'h0000_0000;
      endcase
   end

   // Next-state logic for registers, synchronisers and counters
   always_comb begin
      nxt = cur;
      nxt.pin_sync = {cur.pin_sync[0], i_general_pin_zero_lp};
      nxt.sleep_sync = {cur.sleep_sync[0], i_sleep};
      nxt.lock_e_sync = {cur.lock_e_sync[0], i_fused_enable_lock};
      nxt.lock_p_sync = {cur.lock_p_sync[0], i_fused_period_lock};
      nxt.pwroff_sync = {cur.pwroff_sync[0], i_power_off_request};
      // Clear command acts for one cycle, then the field falls back
      nxt.sys_watchdog_clear = wdt_cfg_pkg::CLEAR_IDLE; // [RL14]
      if (wr_cfg) begin
         nxt.bus_watchdog_period = i_wdata[wdt_cfg_pkg::BUS_WD_PERIOD_LSB +: 2];
         nxt.global_low_power = i_wdata[wdt_cfg_pkg::GLOBAL_LOW_POWER_BIT]; // [RL2]
         nxt.reserved_one = i_wdata[wdt_cfg_pkg::RESERVED_ONE_BIT]; // [RL4]
         nxt.sleep_auto_clear = i_wdata[wdt_cfg_pkg::SLEEP_AUTO_CLEAR_BIT];
         // A locked enable can only be set, never cleared by software
         if (!lock_e || !cur.sys_watchdog_enable) begin
            nxt.sys_watchdog_enable = i_wdata[wdt_cfg_pkg::SYS_WD_ENABLE_BIT]; // [RL7]
         end
         // Locked period only moves while the watchdog is disabled
         if (!lock_p || !cur.sys_watchdog_enable) begin
            nxt.sys_watchdog_period = i_wdata[wdt_cfg_pkg::SYS_WD_PERIOD_LSB +: 2]; // [RL12]
         end
      end
      if (wr_clr) begin
         // Codes other than 0b01 leave the counter alone
         nxt.sys_watchdog_clear = i_wdata[1:0]; // [RL15]
      end
      // Power-off stops even a locked watchdog
      if (cur.pwroff_sync[1]) begin
         nxt.sys_watchdog_enable = 1'b0; // [RL9]
      end
      // Millisecond tick prescaler keeps the second counter in milliseconds rather than clocks
      if (!sys_run || sys_restart) begin
         nxt.tick_cnt = 32'h0000_0000;
         nxt.ms_cnt = 32'h0000_0000;
         nxt.sys_timeout = 1'b0;
      end else if (cur.tick_cnt == 32'(TICK_CYCLES - 1)) begin
         nxt.tick_cnt = 32'h0000_0000;
         if (cur.ms_cnt + 32'h0000_0001 >= sys_limit) begin
            nxt.sys_timeout = 1'b1; // [RL16]
         end else begin
            nxt.ms_cnt = cur.ms_cnt + 32'h0000_0001;
         end
      end else begin
         nxt.tick_cnt = cur.tick_cnt + 32'h0000_0001;
      end
      // Bus watchdog restarts on any bus activity
      if (bus_limit == 32'h0000_0000 || i_bus_activity) begin
         nxt.bus_cnt = 32'h0000_0000;
         nxt.bus_timeout = 1'b0;
      end else if (cur.bus_cnt + 32'h0000_0001 >= bus_limit) begin
         nxt.bus_timeout = 1'b1;
      end else begin
         nxt.bus_cnt = cur.bus_cnt + 32'h0000_0001;
      end
      // Registered read data; clear field reads its current value, upper clear bits read zero, reserved bit 4 reads back
      nxt.rdata = 8'h00;
      if (i_rd && i_addr == wdt_cfg_pkg::LOWPOWER_CONFIG_ADDR) begin
         nxt.rdata = {cur.bus_watchdog_period, cur.global_low_power, cur.reserved_one,
                      cur.sleep_auto_clear, cur.sys_watchdog_enable, cur.sys_watchdog_period};
      end else if (i_rd && i_addr == wdt_cfg_pkg::CLEAR_CONTROL_ADDR) begin
         nxt.rdata = {6'h00, cur.sys_watchdog_clear};
      end
   end

   // Shutdown acts like reset; the clocked shutdown keeps async reset constant-only
   // Fuse and pin synchronisers are cleared too, so fuses are seen again two edges later
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cur <= '0;
         cur.sys_watchdog_period <= wdt_cfg_pkg::SYS_WD_PERIOD_RESET;
      end else if (i_shutdown) begin
         cur <= '0; // [RL8]
         cur.sys_watchdog_period <= wdt_cfg_pkg::SYS_WD_PERIOD_RESET;
      end else begin
         cur <= nxt;
      end
   end

   // Outputs come straight from the state register; only the low-power output
   // merges two flops, which keeps it glitch-free enough for a level signal
   assign o_rdata = cur.rdata;
   assign o_global_low_power = cur.global_low_power | cur.pin_sync[1]; // [RL3]
   assign o_sys_watchdog_timeout = cur.sys_timeout;
   assign o_bus_watchdog_timeout = cur.bus_timeout;
   assign o_bus_watchdog_period = cur.bus_watchdog_period;

   // Checks on the register rules and the counters; all sample on the same clock
   // and are quiet during reset, while shutdown and power-off are excluded where
   // they legitimately override the behaviour being checked
   a_lock_holds_enable: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL8]
      (lock_e && cur.sys_watchdog_enable && !i_shutdown && !cur.pwroff_sync[1])
      |=> cur.sys_watchdog_enable)
      else $error("locked enable dropped");
   a_clear_self_returns: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL14]
      (cur.sys_watchdog_clear == wdt_cfg_pkg::CLEAR_CODE && !wr_clr)
      |=> cur.sys_watchdog_clear == wdt_cfg_pkg::CLEAR_IDLE)
      else $error("clear field did not return");
   a_clear_restarts: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL13]
      (cur.sys_watchdog_clear == wdt_cfg_pkg::CLEAR_CODE && !i_shutdown)
      |=> (cur.ms_cnt == 32'h0000_0000 && cur.tick_cnt == 32'h0000_0000))
      else $error("clear did not restart counter");
   a_other_codes_keep: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL15]
      (sys_run && !sys_restart && !i_shutdown && !cur.pwroff_sync[1] && !wr_cfg
       && cur.tick_cnt == 32'h0000_0000 && cur.ms_cnt == 32'h0000_0000)
      |=> cur.tick_cnt == 32'h0000_0001)
      else $error("counter disturbed");
   a_period_locked: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL12]
      (lock_p && cur.sys_watchdog_enable && !i_shutdown)
      |=> $stable(cur.sys_watchdog_period))
      else $error("locked period changed");
   a_lowpower_or: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL3]
      $rose(cur.pin_sync[1]) |-> o_global_low_power)
      else $error("pin zero not ORed");
   a_sleep_clears: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL5]
      (cur.sleep_auto_clear && cur.sleep_sync[1]) |=> cur.ms_cnt == 32'h0000_0000)
      else $error("sleep auto clear missed");
   a_enable_follows: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL7]
      (wr_cfg && !lock_e && !i_shutdown && !cur.pwroff_sync[1])
      |=> cur.sys_watchdog_enable == $past(i_wdata[wdt_cfg_pkg::SYS_WD_ENABLE_BIT]))
      else $error("enable write not followed");
   a_disabled_quiet: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL6]
      !sys_run |=> !o_sys_watchdog_timeout)
      else $error("timeout while disabled");
   a_poweroff_stops: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL9]
      (cur.pwroff_sync[1] && !wr_cfg) |=> !cur.sys_watchdog_enable)
      else $error("power off did not stop watchdog");

   // Bus watchdog stays silent while its period code is zero
   a_bus_off_quiet: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL1]
      (cur.bus_watchdog_period == 2'h0) |=> !o_bus_watchdog_timeout)
      else $error("bus watchdog fired while off");

   // An idle bus for a whole period must raise the bus timeout
   a_bus_expires: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL1]
      (bus_limit != 32'h0000_0000 && !i_bus_activity && !i_shutdown
       && cur.bus_cnt + 32'h0000_0001 >= bus_limit)
      |=> o_bus_watchdog_timeout)
      else $error("bus watchdog did not expire");

   // The register bit alone forces the global low-power output
   a_lowpower_bit: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL2]
      cur.global_low_power |-> o_global_low_power)
      else $error("low power bit not driven");

   // With both sources low the output must be low
   a_lowpower_idle: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL3]
      (!cur.global_low_power && !cur.pin_sync[1]) |-> !o_global_low_power)
      else $error("low power without a source");

   // Without auto-clear, sleep must not hold the counter at zero
   a_sleep_no_clear: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL5]
      (!cur.sleep_auto_clear && cur.sleep_sync[1] && sys_run && !i_shutdown
       && cur.sys_watchdog_clear != wdt_cfg_pkg::CLEAR_CODE
       && cur.tick_cnt != 32'(TICK_CYCLES - 1))
      |=> cur.tick_cnt != 32'h0000_0000)
      else $error("sleep cleared without auto clear");

   // An enabled, uncleared watchdog advances its prescaler every clock
   a_enable_runs: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL6]
      (sys_run && !sys_restart && !i_shutdown && cur.tick_cnt != 32'(TICK_CYCLES - 1))
      |=> cur.tick_cnt == $past(cur.tick_cnt) + 32'h0000_0001)
      else $error("enabled watchdog not counting");

   // Global shutdown returns enable and period to their reset values
   a_shutdown_resets: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL8]
      i_shutdown |=> (!cur.sys_watchdog_enable
       && cur.sys_watchdog_period == wdt_cfg_pkg::SYS_WD_PERIOD_RESET))
      else $error("shutdown did not reset watchdog");

   // An accepted period write lands as written
   a_period_lands: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL12]
      (wr_cfg && (!lock_p || !cur.sys_watchdog_enable) && !i_shutdown)
      |=> cur.sys_watchdog_period == $past(i_wdata[wdt_cfg_pkg::SYS_WD_PERIOD_LSB +: 2]))
      else $error("period write lost");

   // A clear command is held in the field for its one active cycle
   a_clear_code_lands: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL13]
      (wr_clr && i_wdata[1:0] == wdt_cfg_pkg::CLEAR_CODE && !i_shutdown)
      |=> cur.sys_watchdog_clear == wdt_cfg_pkg::CLEAR_CODE)
      else $error("clear command lost");

   // Running out the period must raise the timeout
   a_timeout_counted: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL16]
      (sys_run && !sys_restart && !i_shutdown && cur.tick_cnt == 32'(TICK_CYCLES - 1)
       && cur.ms_cnt + 32'h0000_0001 >= sys_limit) |=> o_sys_watchdog_timeout)
      else $error("timeout not raised");

   // A raised timeout stays up until the counter is restarted or stopped
   a_timeout_sticky: assert property (@(posedge I_MCLK) disable iff (!I_RST_B) // [RL16]
      (o_sys_watchdog_timeout && sys_run && !sys_restart && !i_shutdown)
      |=> o_sys_watchdog_timeout)
      else $error("timeout dropped while running");
endmodule

// File: wdt_cfg_pkg.sv
package wdt_cfg_pkg;
   // Register offsets on the serial register port
   localparam logic [7:0] LOWPOWER_CONFIG_ADDR = 8'h01;
   localparam logic [7:0] CLEAR_CONTROL_ADDR = 8'h02;
   // Field positions in the low-power configuration register
   localparam int BUS_WD_PERIOD_LSB = 6;
   localparam int GLOBAL_LOW_POWER_BIT = 5;
   localparam int RESERVED_ONE_BIT = 4;
   localparam int SLEEP_AUTO_CLEAR_BIT = 3;
   localparam int SYS_WD_ENABLE_BIT = 2;
   localparam int SYS_WD_PERIOD_LSB = 0;
   // Reset values
   localparam logic [1:0] BUS_WD_PERIOD_RESET = 2'h0;
   localparam logic [1:0] SYS_WD_PERIOD_RESET = 2'h3;
   localparam logic [7:0] CLEAR_CONTROL_RESET = 8'h00;
   // Clear command codes
   localparam logic [1:0] CLEAR_CODE = 2'h1;
   localparam logic [1:0] CLEAR_IDLE = 2'h0;
   // Time base: one tick per millisecond at 125 MHz
   localparam int CLOCK_MHZ = 125;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * CLOCK_MHZ;
   // Bus watchdog periods in microseconds
   localparam int BUS_WD_1_US = 1330;
   localparam int BUS_WD_2_US = 35700;
   localparam int BUS_WD_3_US = 41700;
   localparam int BUS_WD_1_CYCLES = BUS_WD_1_US * CLOCK_MHZ;
   localparam int BUS_WD_2_CYCLES = BUS_WD_2_US * CLOCK_MHZ;
   localparam int BUS_WD_3_CYCLES = BUS_WD_3_US * CLOCK_MHZ;
   // System watchdog periods in seconds, counted in millisecond ticks
   localparam int SYS_WD_0_S = 2;
   localparam int SYS_WD_1_S = 16;
   localparam int SYS_WD_2_S = 64;
   localparam int SYS_WD_3_S = 128;
   localparam int MS_PER_S = 1000;
endpackage

// File: wdt_host.sv
`timescale 1ns/1ps
// Host on the register port: each access is one strobe, driven 1 ns after an edge
module wdt_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata
);
   // Idle bus from time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // Strobe held across exactly one sampling edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = (a == wdt_cfg_pkg::LOWPOWER_CONFIG_ADDR) ? (d | 8'h10) : d;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
   endtask
   // Read data is registered, so it is taken one edge after the strobe edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_rd = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      o_rd = 1'b0;
      d = i_rdata;
   endtask
   // Counter cleared first so a new period never sees a stale count
   task automatic set_period(input logic [7:0] cfg);
      write_reg(wdt_cfg_pkg::CLEAR_CONTROL_ADDR, 8'h01);
      write_reg(wdt_cfg_pkg::LOWPOWER_CONFIG_ADDR, cfg);
   endtask
endmodule

// File: tb_wdt_cfg.sv
`timescale 1ns/1ps
module tb_wdt_cfg;
   localparam logic [7:0] CFG = wdt_cfg_pkg::LOWPOWER_CONFIG_ADDR;
   localparam logic [7:0] CLR = wdt_cfg_pkg::CLEAR_CONTROL_ADDR;
   logic I_MCLK = 1'b0;
   logic I_RST_B = 1'b0;
   logic shdn, poff, lock_en, lock_per;
   logic sleep, pin_lp, bus_act;
   logic wr, rd, glp, sys_to, bus_to;
   logic [7:0] addr, wdata, rdata, rv;
   logic [1:0] bus_per;
   logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
   int mismatches = 0;
   int comparisons = 0;
   // Free-running 125 MHz clock
   always #4 I_MCLK = ~I_MCLK;
   // Shortened time base: 2 s period is 16 cycles here
   wdt_cfg #(.TICK_CYCLES(4), .BUS_WD_1_CYCLES(5), .BUS_WD_2_CYCLES(6), .BUS_WD_3_CYCLES(7),
      .MS_PER_S(2)) i_wdt_cfg (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .i_shutdown(shdn),
      .i_power_off_request(poff), .i_fused_enable_lock(lock_en),
      .i_fused_period_lock(lock_per), .i_sleep(sleep), .i_general_pin_zero_lp(pin_lp),
      .i_bus_activity(bus_act), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata), .o_global_low_power(glp), .o_sys_watchdog_timeout(sys_to),
      .o_bus_watchdog_timeout(bus_to), .o_bus_watchdog_period(bus_per));
   wdt_host i_wdt_host (.i_clk(I_MCLK), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   // Bounded wait for a timeout flag; the whole bound runs unless the flag is seen first
   task automatic wait_flag(input string n, input logic e, input int lim, input logic bus);
      logic seen;
      seen = 1'b0;
      for (int k = 0; k < lim && !seen; k++) begin
         @(posedge I_MCLK);
         #1;
         seen = ((bus ? bus_to : sys_to) === 1'b1);
      end
      chkb(n, e, seen);
      if (e && !seen) final_report();
   endtask
   // One spare edge so registered outputs have settled
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      i_wdt_host.write_reg(a, d);
      @(posedge I_MCLK);
      #1;
   endtask
   task automatic rdreg(input logic [7:0] a, input logic [7:0] e, input string n);
      i_wdt_host.read_reg(a, rv);
      chk8(n, e & 8'hEF, rv & 8'hEF);
   endtask
   // Hang guard
   initial begin
      #200000;
      mismatches++;
      final_report();
   end
   // Main sequence
   initial begin
      shdn = 1'b0;
      poff = 1'b0;
      lock_en = 1'b0;
      lock_per = 1'b0;
      sleep = 1'b0;
      pin_lp = 1'b0;
      bus_act = 1'b0;
      repeat (12) @(posedge I_MCLK);
      #1 I_RST_B = 1'b1;
      repeat (3) @(posedge I_MCLK);
      #1;
      rdreg(CFG, 8'h03, "cfg reset");
      rdreg(CLR, 8'h00, "clr reset");
      rdreg(8'h07, 8'h00, "unmapped");
      for (int c = 0; c < 4; c++) begin
         w(CFG, {c[1:0], 6'h03});
         chk8("bus period", {6'h00, c[1:0]}, {6'h00, bus_per});
         @(posedge I_MCLK);
         #1 bus_act = 1'b1;
         @(posedge I_MCLK);
         #1 bus_act = 1'b0;
         wait_flag("bus timeout", c != 0, 20, 1'b1);
      end
      w(CFG, 8'h23);
      chkb("low power set", 1'b1, glp);
      w(CFG, 8'h03);
      chkb("low power clear", 1'b0, glp);
      pin_lp = 1'b1;
      repeat (4) @(posedge I_MCLK);
      #1 chkb("pin low power", 1'b1, glp);
      pin_lp = 1'b0;
      i_wdt_host.set_period(8'h04);
      wait_flag("wd early", 1'b0, 10, 1'b0);
      wait_flag("wd expire", 1'b1, 20, 1'b0);
      w(CFG, 8'h00);
      chkb("wd disabled", 1'b0, sys_to);
      w(CFG, 8'h04);
      repeat (6) w(CLR, 8'h01);
      chkb("wd kept alive", 1'b0, sys_to);
      rdreg(CLR, 8'h00, "clear self");
      foreach (codes[i]) begin
         w(CLR, 8'h01);
         repeat (10) w(CLR, {6'h00, codes[i]});
         chkb("clear ignored", 1'b1, sys_to);
      end
      w(CLR, 8'h01);
      w(CFG, 8'h0C);
      sleep = 1'b1;
      wait_flag("sleep hold", 1'b0, 40, 1'b0);
      sleep = 1'b0;
      wait_flag("sleep off", 1'b1, 40, 1'b0);
      w(CFG, 8'h04);
      w(CLR, 8'h01);
      sleep = 1'b1;
      wait_flag("sleep no clear", 1'b1, 40, 1'b0);
      sleep = 1'b0;
      w(CFG, 8'h00);
      rdreg(CFG, 8'h00, "en unlocked");
      lock_en = 1'b1;
      lock_per = 1'b1;
      repeat (3) @(posedge I_MCLK);
      #1;
      w(CFG, 8'h04);
      w(CFG, 8'h03);
      rdreg(CFG, 8'h04, "en locked");
      wait_flag("locked runs", 1'b1, 40, 1'b0);
      poff = 1'b1;
      repeat (4) @(posedge I_MCLK);
      #1 poff = 1'b0;
      rdreg(CFG, 8'h00, "power off");
      w(CFG, 8'h01);
      rdreg(CFG, 8'h01, "period free");
      w(CFG, 8'h2C);
      shdn = 1'b1;
      @(posedge I_MCLK);
      #1 shdn = 1'b0;
      rdreg(CFG, 8'h03, "shutdown");
      final_report();
   end
endmodule
